// ==== dv/asp_host_props.sv ====
// assertion checker for the sram host port controller
`timescale 1ns/1ns
module asp_host_props #(
  parameter int RECOVER_CYCLES = asp_pkg::REC_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic RETAIN,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic WR_DONE,
  input wire logic [asp_pkg::ADDR_W-1:0] WORD_INDEX,
  input wire asp_pkg::asp_strobe_t STROBES,
  input wire logic [asp_pkg::DATA_W-1:0] DATA_LANES_O,
  input wire logic DATA_LANES_OE
);
  wire sel_n = STROBES.select_n;
  wire st_n = STROBES.store_n;
  wire de_n = STROBES.drive_en_n;
  wire [1:0] ln = {STROBES.high_lane_enable_n, STROBES.low_lane_enable_n};
  int rec_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // cycles since reset or retention release
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) rec_q <= 0;
    else if (RETAIN) rec_q <= 0;
    else if (rec_q < RECOVER_CYCLES) rec_q <= rec_q + 1;
  end
  chk_no_contention: assert property (DATA_LANES_OE |-> de_n)
    else $error("controller drives lanes during read");
  chk_read_no_store: assert property (!de_n |-> st_n)
    else $error("store and drive enable low together");
  chk_lane_select: assert property (!sel_n |-> ln != 2'h3)
    else $error("selected with no lane enabled");
  chk_write_width: assert property ($fell(st_n) |-> !st_n [*5])
    else $error("write strobe too short");
  chk_write_data: assert property ($fell(st_n) |=>
    ($stable(DATA_LANES_O) && DATA_LANES_OE) [*5])
    else $error("write data not held");
  chk_index_hold: assert property (!sel_n && $past(!sel_n) |->
    $stable(WORD_INDEX) && $stable(ln))
    else $error("index or lanes moved during access");
  chk_write_done: assert property ($rose(st_n) |-> WR_DONE)
    else $error("write done not flagged");
  chk_read_sample: assert property ($fell(de_n) |-> ##[6:12] RD_VALID)
    else $error("read result not delivered in time");
  chk_recover_wait: assert property (rec_q > 0 && rec_q < RECOVER_CYCLES
    |-> !REQ_READY)
    else $error("ready before recovery time");
  chk_retain_idle: assert property (RETAIN [*2] |-> !REQ_READY && sel_n)
    else $error("access during retention");
  cov_write: cover property ($fell(st_n));
  cov_read: cover property (RD_VALID);
  cov_retain: cover property (RETAIN [*2]);
endmodule : asp_host_props
bind asp_host asp_host_props #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_props (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .RETAIN(RETAIN),
  .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .WR_DONE(WR_DONE),
  .WORD_INDEX(WORD_INDEX), .STROBES(STROBES),
  .DATA_LANES_O(DATA_LANES_O), .DATA_LANES_OE(DATA_LANES_OE));

// ==== dv/asp_host_test.sv ====
// self-checking bench for the sram host port controller
`timescale 1ns/1ns
module asp_host_test;
  logic CLK_SYS = 1'b0, RESETN = 1'b0, REQ_VALID = 1'b0, RETAIN = 1'b0;
  asp_pkg::asp_req_t REQ = '0;
  logic REQ_READY, RD_VALID, WR_DONE, DATA_LANES_OE;
  logic [15:0] RD_DATA, DATA_LANES_O, dq, sram_q;
  logic [16:0] WORD_INDEX;
  asp_pkg::asp_strobe_t STROBES;
  logic [15:0] ref_mem [int];
  int num_errors = 0, compares = 0;
  assign dq = DATA_LANES_OE ? DATA_LANES_O : sram_q;
  asp_host #(.RECOVER_CYCLES(20)) u_dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .RETAIN(RETAIN), .REQ_READY(REQ_READY),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .WR_DONE(WR_DONE),
    .WORD_INDEX(WORD_INDEX), .STROBES(STROBES), .DATA_LANES_O(DATA_LANES_O),
    .DATA_LANES_OE(DATA_LANES_OE), .DATA_LANES_I(dq));
  asp_sram_model u_sram (.index(WORD_INDEX), .pins(STROBES), .din(dq),
    .dout(sram_q));
  initial forever #5 CLK_SYS = ~CLK_SYS;
  task automatic check(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [15:0] exp_rd(int a, logic [1:0] en);
    return ref_mem[a] & {{8{en[1]}}, {8{en[0]}}};
  endfunction : exp_rd
  task automatic xfer(logic w, int a, logic [15:0] d, logic [1:0] en);
    int n = 0;
    REQ = '{a[16:0], d, en[0], en[1], w};
    REQ_VALID = 1'b1;
    do @(posedge CLK_SYS); while (REQ_READY !== 1'b1 && ++n < 500);
    #1 REQ_VALID = 1'b0;
    n = 0;
    while ((w ? WR_DONE : RD_VALID) !== 1'b1 && n++ < 100) @(posedge CLK_SYS) #1;
    check("done flag", 16'h1, {15'h0, w ? WR_DONE : RD_VALID});
    if (en[0] && w) ref_mem[a][7:0] = d[7:0];
    if (en[1] && w) ref_mem[a][15:8] = d[15:8];
    if (!w) check("read data", exp_rd(a, en), RD_DATA);
  endtask : xfer
  task automatic end_of_test;
    $display("compares %0d, num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(79));
    repeat (2) @(posedge CLK_SYS);
    #1 RESETN = 1'b1;
    xfer(1, 17'h1ffff, 16'hffff, 2'h3);
    xfer(1, 17'h1ffff, 16'h1234, 2'h1);
    xfer(1, 17'h1ffff, 16'h5600, 2'h2);
    for (int e = 1; e < 4; e++) xfer(0, 17'h1ffff, 16'h0, e[1:0]);
    $display("byte lane test done");
    REQ = '{17'h5, 16'h0, 1'b0, 1'b0, 1'b1};
    REQ_VALID = 1'b1;
    repeat (6) @(posedge CLK_SYS);
    #1 REQ_VALID = 1'b0;
    check("select idle", 16'h1, {15'h0, STROBES.select_n});
    RETAIN = 1'b1;
    repeat (4) @(posedge CLK_SYS);
    #1 RETAIN = 1'b0;
    check("retain ready", 16'h0, {15'h0, REQ_READY});
    xfer(0, 17'h1ffff, 16'h0, 2'h3);
    $display("refusal and retention test done");
    for (int i = 0; i < 25; i++) begin
      xfer(1, i * 5243, 16'($urandom), 2'h3);
      xfer(1, i * 5243, 16'($urandom), 2'($urandom % 3 + 1));
      xfer(0, i * 5243, 16'h0, 2'($urandom % 3 + 1));
    end
    $display("random test done");
    end_of_test();
  end
endmodule : asp_host_test

// ==== dv/asp_sram_model.sv ====
// behavioural model of the asynchronous sram on the far side
`timescale 1ns/1ns
module asp_sram_model (
  input wire logic [asp_pkg::ADDR_W-1:0] index,
  input wire asp_pkg::asp_strobe_t pins,
  input wire logic [asp_pkg::DATA_W-1:0] din,
  output logic [asp_pkg::DATA_W-1:0] dout
);
  logic [15:0] mem [0:131071];
  wire le = !pins.low_lane_enable_n;
  wire he = !pins.high_lane_enable_n;
  wire act = !pins.select_n && (le || he);
  wire wr = act && !pins.store_n;
  wire rd = act && pins.store_n && !pins.drive_en_n;
  wire rd_d;
  wire [asp_pkg::ADDR_W-1:0] idx_d;
  // valid late, released at once
  assign #(50, 0) rd_d = rd;
  // old word stays on the lanes a while after the index moves
  assign #10 idx_d = index;
  initial dout = 16'h5a5a;
  always @* begin
    if (wr && le) mem[index][7:0] = din[7:0];
    if (wr && he) mem[index][15:8] = din[15:8];
  end
  // floating lanes toggle so stale data never looks valid
  always #3 begin
    dout[7:0] = (rd_d && le) ? mem[idx_d][7:0] : ~dout[7:0];
    dout[15:8] = (rd_d && he) ? mem[idx_d][15:8] : ~dout[15:8];
  end
endmodule : asp_sram_model

// ==== rtl/asp_host.sv ====
// host controller driving an asynchronous 128k x 16 sram over its pins
`timescale 1ns/1ns
module asp_host #(
  parameter int RECOVER_CYCLES = asp_pkg::REC_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input wire asp_pkg::asp_req_t REQ,
  input wire logic RETAIN,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [asp_pkg::DATA_W-1:0] RD_DATA,
  output logic WR_DONE,
  output logic [asp_pkg::ADDR_W-1:0] WORD_INDEX,
  output asp_pkg::asp_strobe_t STROBES,
  output logic [asp_pkg::DATA_W-1:0] DATA_LANES_O,
  output logic DATA_LANES_OE,
  input wire logic [asp_pkg::DATA_W-1:0] DATA_LANES_I
);
  asp_pkg::asp_state_t state_q;
  logic [asp_pkg::CNT_W-1:0] cnt_q;
  asp_pkg::asp_req_t req_q;
  logic [asp_pkg::DATA_W-1:0] s1_q, s2_q, s3_q;
  // decoded controls
  logic take;
  logic [asp_pkg::DATA_W-1:0] lane_mask;
  logic rd_due;
  logic rd_settled;
  logic rd_ok;

  // three-stage sampling of the read lanes
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= DATA_LANES_I;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= asp_pkg::ST_RECOVER;
      cnt_q <= '0;
      req_q <= '0;
    end else begin
      case (state_q)
        asp_pkg::ST_RECOVER: begin
          // wait out recovery after retention or reset
          if (RETAIN) begin
            cnt_q <= '0;
          end else if (cnt_q >= asp_pkg::CNT_W'(RECOVER_CYCLES - 1)) begin
            cnt_q <= '0;
            state_q <= asp_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        asp_pkg::ST_IDLE: begin
          cnt_q <= '0;
          // an offer seen while ready is low simply waits
          // a take wins over retention, as ready was already shown
          if (take) begin
            req_q <= REQ; // held for whole access
            state_q <= REQ.write ? asp_pkg::ST_WRITE : asp_pkg::ST_READ;
          end else if (RETAIN) begin
            state_q <= asp_pkg::ST_RECOVER;
          end
        end
        asp_pkg::ST_WRITE: begin
          // strobe low long enough; data valid throughout
          if (cnt_q >= asp_pkg::CNT_W'(asp_pkg::WP_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= asp_pkg::ST_WGAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        asp_pkg::ST_WGAP: begin
          // finish write cycle time
          if (cnt_q >= asp_pkg::CNT_W'(asp_pkg::WC_CYC - asp_pkg::WP_CYC)) begin
            cnt_q <= '0;
            state_q <= asp_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        asp_pkg::ST_READ: begin
          // access time then sampler latency
          if (rd_ok) begin
            cnt_q <= '0;
            state_q <= asp_pkg::ST_RGAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        asp_pkg::ST_RGAP: begin
          // device release time before lanes may be driven
          if (cnt_q >= asp_pkg::CNT_W'(asp_pkg::HZ_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= asp_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= asp_pkg::ST_RECOVER;
      endcase
    end
  end

  // request decode and read completion
  always_comb begin
    // ready is only ever high while idle, so this is the take edge
    take = REQ_VALID && REQ_READY && (REQ.low_en || REQ.high_en);
    // lanes the current access asked for
    lane_mask = {{asp_pkg::BYTE_W{req_q.high_en}},
                 {asp_pkg::BYTE_W{req_q.low_en}}};
    // access time plus sampler stages, counted from the take edge, a cycle before the strobes fall
    rd_due = cnt_q >= asp_pkg::CNT_W'(asp_pkg::RD_CYC + asp_pkg::SYNC_CYC);
    // second and third stage agree on the enabled lanes
    rd_settled = ((s2_q ^ s3_q) & lane_mask) == '0;
    rd_ok = rd_due && rd_settled;
  end

  // index moves on the take edge, a cycle before the strobes fall
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      WORD_INDEX <= '0;
    end else if (take) begin
      // then holds until the next take
      WORD_INDEX <= REQ.index;
    end
  end

  // strobes, registered; all high outside an access
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      STROBES <= '1;
    end else begin
      STROBES <= '1;
      case (state_q)
        asp_pkg::ST_WRITE: begin
          // select, store and lanes fall together
          STROBES.select_n <= 1'b0;
          STROBES.store_n <= 1'b0;
          STROBES.low_lane_enable_n <= ~req_q.low_en;
          STROBES.high_lane_enable_n <= ~req_q.high_en;
        end
        asp_pkg::ST_READ: begin
          // store stays high so a read never writes
          STROBES.select_n <= 1'b0;
          STROBES.drive_en_n <= 1'b0;
          STROBES.low_lane_enable_n <= ~req_q.low_en;
          STROBES.high_lane_enable_n <= ~req_q.high_en;
        end
        default: begin
          // gaps, idle and recovery: deselected
          STROBES <= '1;
        end
      endcase
    end
  end

  // write data and lane drive
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      DATA_LANES_O <= '0;
      DATA_LANES_OE <= 1'b0;
    end else begin
      DATA_LANES_OE <= 1'b0;
      // data itself is left in place between writes
      if (state_q == asp_pkg::ST_WRITE) begin
        DATA_LANES_O <= req_q.wdata;
        // drive enable is high here, so no clash
        DATA_LANES_OE <= 1'b1;
      end else if (state_q == asp_pkg::ST_WGAP && cnt_q == '0) begin
        // one cycle past the window covers data hold
        DATA_LANES_OE <= 1'b1;
      end
    end
  end

  // ready drops on the cycle after a take so one request is taken once
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REQ_READY <= 1'b0;
    end else begin
      // registered, so it lags the state by one cycle
      REQ_READY <= (state_q == asp_pkg::ST_IDLE) && !RETAIN &&
                   !(REQ_VALID && REQ_READY);
    end
  end

  // read result; an unselected byte reads as zero
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RD_VALID <= 1'b0;
      RD_DATA <= '0;
    end else begin
      RD_VALID <= 1'b0;
      if (state_q == asp_pkg::ST_READ && rd_ok) begin
        RD_VALID <= 1'b1;
        // floating lanes toggle, so mask rather than trust them
        RD_DATA <= s3_q & lane_mask;
      end
    end
  end

  // one pulse on the cycle the store strobe rises
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      WR_DONE <= 1'b0;
    end else begin
      // first gap cycle is the one after the window closes
      WR_DONE <= (state_q == asp_pkg::ST_WGAP) && (cnt_q == '0);
    end
  end
endmodule : asp_host

// ==== rtl/asp_pkg.sv ====
// constants and carrier types for the sram host port controller
package asp_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RC_NS = 55;
  localparam int T_AA_NS = 55;
  localparam int T_WC_NS = 55;
  localparam int T_WP_NS = 45;
  localparam int T_DW_NS = 25;
  localparam int T_HZ_NS = 20;
  localparam int T_RECOVER_MS = 5;
  localparam int NS_PER_MS = 1000000;
  // least times round up
  localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = T_RECOVER_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int CNT_W = 20;
  // sampler stages between the lane pins and the captured word
  localparam int SYNC_CYC = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] index;
    logic [DATA_W-1:0] wdata;
    logic low_en;
    logic high_en;
    logic write;
  } asp_req_t;

  typedef struct packed {
    logic select_n;
    logic store_n;
    logic drive_en_n;
    logic low_lane_enable_n;
    logic high_lane_enable_n;
  } asp_strobe_t;

  typedef enum logic [2:0] {
    ST_RECOVER, ST_IDLE, ST_WRITE, ST_WGAP, ST_READ, ST_RGAP
  } asp_state_t;
endpackage : asp_pkg
